/* File: core/sfr_slice_params.svh */
/*
  Offsets, field positions and reset values of the register slice.
  Assumes the byte-wide register port of the CPU core; no clock figures.
*/
`ifndef SFR_SLICE_PARAMS_SVH
`define SFR_SLICE_PARAMS_SVH
`define ADDR_SERIAL2_CONTROL 8'h8e
`define ADDR_SERIAL2_DATA 8'h8f
`define ADDR_PORT_ONE_DATA 8'h90
`define ADDR_PORT_ZERO_PP 8'h91
`define ADDR_PORT_ZERO_LCD 8'h92
`define ADDR_PORT_TWO_MODE 8'h93
`define ADDR_OPTION 8'h94
`define ADDR_INT_FLAGS 8'h95
`define ADDR_PORT_ONE_WAKE 8'h96
`define BIT_S2_FRAME 7
`define BIT_S2_RX_EN 4
`define BIT_S2_TX9 3
`define BIT_S2_RX9 2
`define BIT_S2_TXDONE 1
`define BIT_S2_RXDONE 0
`define BIT_SINGLE_WIRE 7
`define BIT_TOUCH_DONE 5
`define BIT_ADC_DONE 4
`define BIT_EXT2_EDGE 2
`define BIT_P1_CHANGE 1
`define BIT_T3_FLAG 0
`define FLD_WDT 5:4
`define FLD_ADC_CLK 3:2
`define FLD_MODE_ONE 3:2
`define FLD_MODE_ZERO 1:0
`define RST_PORT_ONE 8'hff
`define RST_PORT_ZERO 8'h00
`define RST_PIN_MODE 2'h1
`define RST_BYTE 8'h00
`define RST_WAKE 4'h0
`endif

/* File: core/sfr_slice_pkg.sv */
/*
  Types shared by the register slice.
  Assumes the constants header for numeric values.
*/
package sfr_slice_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic tx_start;
    logic tx_stop_begin;
    logic rx_stop_sample;
    logic rx_ninth;
    logic [7:0] rx_data;
  } serial_event_type;

  typedef struct packed {
    logic touch_done;
    logic touch_start;
    logic adc_done;
    logic adc_start;
    logic ext2_pin;
    logic ext2_isr;
    logic [3:0] port_one_pins;
    logic port_one_isr;
    logic timer3_done;
    logic timer3_isr;
  } flag_event_type;

  typedef enum logic [1:0] {
    adc_div32 = 2'h0,
    adc_div16 = 2'h1,
    adc_div8 = 2'h2,
    adc_div4 = 2'h3
  } adc_div_type;

  typedef enum logic [1:0] {
    wdt_400ms = 2'h0,
    wdt_200ms = 2'h1,
    wdt_100ms = 2'h2,
    wdt_50ms = 2'h3
  } wdt_period_type;
endpackage : sfr_slice_pkg

/* File: core/sfr_slice_serial2_port_option_flags.sv */
/*
  Register slice 8eh..96h: second serial port control and buffer, port
  data and enables, port 2 pin modes, option bits and interrupt flags.
  Assumes a byte register port with read data one cycle after the read
  strobe, and engine event pulses synchronous to clk_i.
*/
// The address-and-strobe port was chosen for this implementation.
// Behaviour
// - Bit 7 picks 8-bit or 9-bit frames; bit 4 enables receive.
// - In 9-bit frames the transmit ninth-bit field is sent as bit nine.
// - In 9-bit frames the received ninth bit is stored in control bit 2.
// - Transmit-done bit 1 sets at stop-bit start; only software clears it.
// - Receive-done bit 0 sets at stop-bit sampling; only software clears it.
// - Buffer writes feed transmit; reads return separate receive data.
// - Each port 0 push-pull bit enables that pin's driver; resets to zero.
// - Each port 0 LCD bias bit selects half-bias output; resets to zero.
// - Port 2 pins 1 and 0 mode fields at 3:2 and 1:0, reset 01.
// - Option bit 7 puts serial port one into single-wire mode.
// - Option bits 5:4 select watchdog period 400, 200, 100 or 50 ms.
// - Option bits 3:2 divide the system clock by 32, 16, 8 or 4.
// - Touch-done bit 5 sets on completion; DFh write or new start clears.
// - ADC-done bit 4 sets on completion; EFh write or new start clears.
// - External interrupt 2 flag bit 2 sets on each falling pin edge.
// - External interrupt 2 flag clears on service entry or FBh write.
// - Change flag bit 1 sets on a pin change, gated per pin by its wake enable.
// - Port 1 change flag clears on service entry or FDh write.
// - Timer 3 flag bit 0 sets when timer 3 reaches its prescale count.
// - Four wake enables allow change detection per pin P1.0 to P1.3.
`timescale 1ns/10ps
`include "sfr_slice_params.svh"
module sfr_slice_serial2_port_option_flags (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire sfr_slice_pkg::bus_req_type bus_i,
  output logic [7:0] rdata_o,
  input wire sfr_slice_pkg::serial_event_type serial2_i,
  output logic serial2_nine_bit_o,
  output logic serial2_receive_enable_o,
  output logic serial2_tx_ninth_bit_o,
  output logic [7:0] serial2_tx_data_o,
  output logic serial2_tx_load_o,
  input wire sfr_slice_pkg::flag_event_type flag_ev_i,
  output logic [7:0] port_one_data_o,
  output logic [7:0] port_zero_pushpull_enable_o,
  output logic [7:0] port_zero_lcd_bias_enable_o,
  output logic [1:0] pin_two_one_mode_o,
  output logic [1:0] pin_two_zero_mode_o,
  output logic serial1_single_wire_o,
  output sfr_slice_pkg::wdt_period_type watchdog_period_select_o,
  output sfr_slice_pkg::adc_div_type adc_clock_divider_o,
  output logic [7:0] interrupt_flags_o
);

  // Register state, one current and one next value per group.
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] tx_buf_reg;
  logic [7:0] tx_buf_next;
  logic tx_load_reg;
  logic tx_load_next;
  logic [7:0] rx_buf_reg;
  logic [7:0] rx_buf_next;
  logic [7:0] p1_reg;
  logic [7:0] p1_next;
  logic [7:0] pp_reg;
  logic [7:0] pp_next;
  logic [7:0] lcd_reg;
  logic [7:0] lcd_next;
  logic [3:0] p2mode_reg;
  logic [3:0] p2mode_next;
  logic [7:0] opt_reg;
  logic [7:0] opt_next;
  logic [3:0] wake_reg;
  logic [3:0] wake_next;
  logic ext2_prev_reg;
  logic ext2_prev_next;
  logic [3:0] p1_prev_reg;
  logic [3:0] p1_prev_next;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rx_accept;
  logic ext2_fall;
  logic p1_change;

  // Write strobe aimed at one register address.
  function automatic logic hit(input sfr_slice_pkg::bus_req_type b,
                               input logic [7:0] a);
    hit = b.wr && (b.addr == a);
  endfunction : hit

  // Mask kept by a flag write: a written zero clears, a written one keeps.
  function automatic logic [7:0] keep_mask(
    input sfr_slice_pkg::bus_req_type b);
    keep_mask = hit(b, `ADDR_INT_FLAGS) ? b.wdata : 8'hff;
  endfunction : keep_mask

  // Event decode shared by the control and flag groups.
  assign rx_accept = serial2_i.rx_stop_sample
                     & ctrl_reg[`BIT_S2_RX_EN];
  assign ext2_fall = ext2_prev_reg & ~flag_ev_i.ext2_pin;
  assign p1_change =
    |((p1_prev_reg ^ flag_ev_i.port_one_pins) & wake_reg);

  // Hardware sets are applied after the software write so that a set wins
  // over a zero written in the same cycle.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (hit(bus_i, `ADDR_SERIAL2_CONTROL)) begin
      ctrl_next = bus_i.wdata;
    end
    if (serial2_i.tx_stop_begin) begin
      ctrl_next[`BIT_S2_TXDONE] = 1'b1;
    end
    if (rx_accept) begin
      ctrl_next[`BIT_S2_RXDONE] = 1'b1;
      if (ctrl_reg[`BIT_S2_FRAME]) begin
        ctrl_next[`BIT_S2_RX9] = serial2_i.rx_ninth;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_reg <= `RST_BYTE;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // A write to the data buffer feeds the transmit side only; the strobe
  // tells the shifter that a new byte is waiting.
  always_comb begin
    tx_buf_next = tx_buf_reg;
    tx_load_next = 1'b0;
    if (hit(bus_i, `ADDR_SERIAL2_DATA)) begin
      tx_buf_next = bus_i.wdata;
      tx_load_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_buf_reg <= `RST_BYTE;
      tx_load_reg <= 1'b0;
    end else begin
      tx_buf_reg <= tx_buf_next;
      tx_load_reg <= tx_load_next;
    end
  end

  // Receive storage is separate, so a transmit write never disturbs it.
  always_comb begin
    rx_buf_next = rx_buf_reg;
    if (rx_accept) begin
      rx_buf_next = serial2_i.rx_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_buf_reg <= `RST_BYTE;
    end else begin
      rx_buf_reg <= rx_buf_next;
    end
  end

  // Port 1 output latch; sampling of the pins lives outside this slice.
  always_comb begin
    p1_next = p1_reg;
    if (hit(bus_i, `ADDR_PORT_ONE_DATA)) begin
      p1_next = bus_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      p1_reg <= `RST_PORT_ONE;
    end else begin
      p1_reg <= p1_next;
    end
  end

  // Push-pull and LCD bias enables go straight to the port 0 pad controls.
  always_comb begin
    pp_next = pp_reg;
    if (hit(bus_i, `ADDR_PORT_ZERO_PP)) begin
      pp_next = bus_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pp_reg <= `RST_PORT_ZERO;
    end else begin
      pp_reg <= pp_next;
    end
  end

  always_comb begin
    lcd_next = lcd_reg;
    if (hit(bus_i, `ADDR_PORT_ZERO_LCD)) begin
      lcd_next = bus_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lcd_reg <= `RST_PORT_ZERO;
    end else begin
      lcd_reg <= lcd_next;
    end
  end

  // Code 11 is stored as written; the pin logic must treat it as undefined.
  always_comb begin
    p2mode_next = p2mode_reg;
    if (hit(bus_i, `ADDR_PORT_TWO_MODE)) begin
      p2mode_next = bus_i.wdata[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      p2mode_reg <= {`RST_PIN_MODE, `RST_PIN_MODE};
    end else begin
      p2mode_reg <= p2mode_next;
    end
  end

  // Option bits feed the serial, watchdog and ADC clock logic elsewhere.
  always_comb begin
    opt_next = opt_reg;
    if (hit(bus_i, `ADDR_OPTION)) begin
      opt_next = bus_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      opt_reg <= `RST_BYTE;
    end else begin
      opt_reg <= opt_next;
    end
  end

  // Wake enables sit just above the flag register, low four bits only.
  always_comb begin
    wake_next = wake_reg;
    if (hit(bus_i, `ADDR_PORT_ONE_WAKE)) begin
      wake_next = bus_i.wdata[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wake_reg <= `RST_WAKE;
    end else begin
      wake_reg <= wake_next;
    end
  end

  // History for edge detection. The interrupt pin history resets high, its
  // idle level, so that leaving reset never looks like a falling edge.
  always_comb begin
    ext2_prev_next = flag_ev_i.ext2_pin;
    p1_prev_next = flag_ev_i.port_one_pins;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ext2_prev_reg <= 1'b1;
      p1_prev_reg <= 4'h0;
    end else begin
      ext2_prev_reg <= ext2_prev_next;
      p1_prev_reg <= p1_prev_next;
    end
  end

  // Clears from writes, starts and service entry come first and hardware
  // sets last, so an event in the same cycle as a clear is never lost.
  // Bits 7, 6 and 3 have no flag behind them and always read zero.
  always_comb begin
    flags_next = flags_reg & keep_mask(bus_i);
    flags_next[7:6] = 2'h0;
    flags_next[3] = 1'b0;
    if (flag_ev_i.touch_start) begin
      flags_next[`BIT_TOUCH_DONE] = 1'b0;
    end
    if (flag_ev_i.adc_start) begin
      flags_next[`BIT_ADC_DONE] = 1'b0;
    end
    if (flag_ev_i.ext2_isr) begin
      flags_next[`BIT_EXT2_EDGE] = 1'b0;
    end
    if (flag_ev_i.port_one_isr) begin
      flags_next[`BIT_P1_CHANGE] = 1'b0;
    end
    if (flag_ev_i.timer3_isr) begin
      flags_next[`BIT_T3_FLAG] = 1'b0;
    end
    if (flag_ev_i.touch_done) begin
      flags_next[`BIT_TOUCH_DONE] = 1'b1;
    end
    if (flag_ev_i.adc_done) begin
      flags_next[`BIT_ADC_DONE] = 1'b1;
    end
    if (ext2_fall) begin
      flags_next[`BIT_EXT2_EDGE] = 1'b1;
    end
    if (p1_change) begin
      flags_next[`BIT_P1_CHANGE] = 1'b1;
    end
    if (flag_ev_i.timer3_done) begin
      flags_next[`BIT_T3_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flags_reg <= `RST_BYTE;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Read data is registered and stands for the one cycle after the read
  // strobe; it returns to zero otherwise so stale data never lingers.
  always_comb begin
    rdata_next = 8'h00;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        `ADDR_SERIAL2_CONTROL: rdata_next = ctrl_reg;
        `ADDR_SERIAL2_DATA: rdata_next = rx_buf_reg;
        `ADDR_PORT_ONE_DATA: rdata_next = p1_reg;
        `ADDR_PORT_ZERO_PP: rdata_next = pp_reg;
        `ADDR_PORT_ZERO_LCD: rdata_next = lcd_reg;
        `ADDR_PORT_TWO_MODE: rdata_next = {4'h0, p2mode_reg};
        `ADDR_OPTION: rdata_next = opt_reg;
        `ADDR_INT_FLAGS: rdata_next = flags_reg;
        `ADDR_PORT_ONE_WAKE: rdata_next = {4'h0, wake_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_reg <= `RST_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Every output comes straight from a register or a gated register bit.
  assign rdata_o = rdata_reg;
  assign serial2_nine_bit_o = ctrl_reg[`BIT_S2_FRAME];
  assign serial2_receive_enable_o = ctrl_reg[`BIT_S2_RX_EN];
  // Only meaningful to the shifter in 9-bit frames.
  assign serial2_tx_ninth_bit_o = ctrl_reg[`BIT_S2_TX9]
                                  & ctrl_reg[`BIT_S2_FRAME];
  assign serial2_tx_data_o = tx_buf_reg;
  assign serial2_tx_load_o = tx_load_reg;
  assign port_one_data_o = p1_reg;
  assign port_zero_pushpull_enable_o = pp_reg;
  assign port_zero_lcd_bias_enable_o = lcd_reg;
  assign pin_two_one_mode_o = p2mode_reg[`FLD_MODE_ONE];
  assign pin_two_zero_mode_o = p2mode_reg[`FLD_MODE_ZERO];
  assign serial1_single_wire_o = opt_reg[`BIT_SINGLE_WIRE];
  assign watchdog_period_select_o =
    sfr_slice_pkg::wdt_period_type'(opt_reg[`FLD_WDT]);
  assign adc_clock_divider_o =
    sfr_slice_pkg::adc_div_type'(opt_reg[`FLD_ADC_CLK]);
  assign interrupt_flags_o = flags_reg;

endmodule : sfr_slice_serial2_port_option_flags

/* File: verification/sfr_slice_props.sv */
/*
  Checker for the register slice: bus timing and flag behaviour.
  Assumes it is bound to the slice top and sees only its ports.
*/
`timescale 1ns/10ps
module sfr_slice_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire sfr_slice_pkg::bus_req_type bus_i,
  input wire logic [7:0] rdata_o,
  input wire sfr_slice_pkg::flag_event_type flag_ev_i,
  input wire logic serial2_nine_bit_o,
  input wire logic serial2_tx_ninth_bit_o,
  input wire logic [7:0] serial2_tx_data_o,
  input wire logic serial2_tx_load_o,
  input wire logic [7:0] port_zero_pushpull_enable_o,
  input wire logic [7:0] interrupt_flags_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire flag_wr = bus_i.wr && (bus_i.addr == 8'h95);
  wire pp_hit = bus_i.addr == 8'h91;
  pp_write_a:
    assert property (bus_i.wr && pp_hit
      |=> port_zero_pushpull_enable_o == $past(bus_i.wdata))
      else $error("push-pull enables missed a write");
  pp_read_a:
    assert property (bus_i.rd && pp_hit
      |=> rdata_o == $past(port_zero_pushpull_enable_o))
      else $error("push-pull read data wrong");
  flag_read_a:
    assert property (bus_i.rd && bus_i.addr == 8'h95
      |=> rdata_o == $past(interrupt_flags_o))
      else $error("flag read data wrong");
  tx_load_a:
    assert property (bus_i.wr && bus_i.addr == 8'h8f |=> serial2_tx_load_o
      && serial2_tx_data_o == $past(bus_i.wdata))
      else $error("transmit buffer not loaded");
  ninth_gate_a:
    assert property (serial2_tx_ninth_bit_o |-> serial2_nine_bit_o)
      else $error("ninth bit sent outside nine-bit frames");
  touch_set_a:
    assert property (flag_ev_i.touch_done |=> interrupt_flags_o[5])
      else $error("touch done flag not set");
  ext2_edge_a:
    assert property ($fell(flag_ev_i.ext2_pin) |=> interrupt_flags_o[2])
      else $error("falling edge flag not set");
  adc_hold_a:
    assert property (interrupt_flags_o[4] && !flag_ev_i.adc_start
      && !(flag_wr && !bus_i.wdata[4]) |=> interrupt_flags_o[4])
      else $error("adc done flag lost");
  flag_clear_a:
    assert property (flag_wr && !bus_i.wdata[5] && !flag_ev_i.touch_done
      |=> !interrupt_flags_o[5])
      else $error("zero write left touch flag set");
  cover property (flag_wr);
  cover property ($fell(flag_ev_i.ext2_pin));
  cover property (serial2_tx_load_o);
endmodule : sfr_slice_checker

/* File: verification/testbench.sv */
/*
  Self-checking bench: a table of register accesses, then serial,
  flag and reset cases. Assumes the slice package and header.
*/
`timescale 1ns/10ps
module testbench;
  typedef struct {logic [7:0] a, d, e; bit w;} row_type;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  sfr_slice_pkg::bus_req_type bus_i = '0;
  sfr_slice_pkg::serial_event_type serial2_i = '0;
  // Idle events keep the edge pin high so no falling edge is faked.
  sfr_slice_pkg::flag_event_type fe0 = 13'h0100;
  sfr_slice_pkg::flag_event_type flag_ev_i = 13'h0100;
  logic [7:0] rdata_o, serial2_tx_data_o, port_one_data_o;
  logic [7:0] port_zero_pushpull_enable_o, port_zero_lcd_bias_enable_o;
  logic [7:0] interrupt_flags_o;
  logic serial2_nine_bit_o, serial2_receive_enable_o;
  logic serial2_tx_ninth_bit_o, serial2_tx_load_o, serial1_single_wire_o;
  logic [1:0] pin_two_one_mode_o, pin_two_zero_mode_o;
  sfr_slice_pkg::wdt_period_type watchdog_period_select_o;
  sfr_slice_pkg::adc_div_type adc_clock_divider_o;
  int mismatches = 0;
  int n_checks = 0;
  row_type rows [16] = '{'{8'h90, 8'h00, 8'hff, 0},
    '{8'h91, 8'h00, 8'h00, 0}, '{8'h92, 8'h00, 8'h00, 0},
    '{8'h93, 8'h00, 8'h05, 0}, '{8'h95, 8'h00, 8'h00, 0},
    '{8'h90, 8'ha5, 8'ha5, 1}, '{8'h91, 8'h3c, 8'h3c, 1},
    '{8'h92, 8'hc3, 8'hc3, 1}, '{8'h93, 8'h0e, 8'h0e, 1},
    '{8'h94, 8'h00, 8'h00, 1}, '{8'h94, 8'h94, 8'h94, 1},
    '{8'h94, 8'ha8, 8'ha8, 1}, '{8'h94, 8'hbc, 8'hbc, 1},
    '{8'h96, 8'h0f, 8'h0f, 1}, '{8'h8e, 8'h98, 8'h98, 1},
    '{8'ha0, 8'h55, 8'h00, 1}};
  logic [7:0] clr [4] = '{8'hdf, 8'hef, 8'hfb, 8'hfd};
  always #12.5 clk_i = ~clk_i;
  sfr_slice_serial2_port_option_flags u_sfr_slice_serial2_port_option_flags (
    .clk_i, .reset_i, .bus_i, .rdata_o, .serial2_i, .serial2_nine_bit_o,
    .serial2_receive_enable_o, .serial2_tx_ninth_bit_o, .serial2_tx_data_o,
    .serial2_tx_load_o, .flag_ev_i, .port_one_data_o,
    .port_zero_pushpull_enable_o, .port_zero_lcd_bias_enable_o,
    .pin_two_one_mode_o, .pin_two_zero_mode_o, .serial1_single_wire_o,
    .watchdog_period_select_o, .adc_clock_divider_o, .interrupt_flags_o);
  task automatic chk(input string n, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    bus_i <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    bus_i <= '0;
    #1 d = rdata_o;
  endtask : rd
  task automatic ev(input sfr_slice_pkg::serial_event_type s,
                    input sfr_slice_pkg::flag_event_type f);
    @(posedge clk_i);
    serial2_i <= s;
    flag_ev_i <= f;
    @(posedge clk_i);
    serial2_i <= '0;
    flag_ev_i <= fe0;
    #1;
  endtask : ev
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin : main
    logic [7:0] v, e;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      e = rows[i].e;
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk("readback", e, v);
      if (rows[i].a == 8'h91) chk("pp", e, port_zero_pushpull_enable_o);
      if (rows[i].a == 8'h92) begin
        chk("lcd", e, port_zero_lcd_bias_enable_o);
      end
      if (rows[i].a == 8'h90) chk("port one", e, port_one_data_o);
      if (rows[i].a == 8'h93) begin
        chk("mode1", 8'(e[3:2]), 8'(pin_two_one_mode_o));
        chk("mode0", 8'(e[1:0]), 8'(pin_two_zero_mode_o));
      end
      if (rows[i].a == 8'h94) begin
        chk("wire", 8'(e[7]), 8'(serial1_single_wire_o));
        chk("wdt", 8'(e[5:4]), 8'(watchdog_period_select_o));
        chk("adc", 8'(e[3:2]), 8'(adc_clock_divider_o));
      end
    end
    $display("table test done");
    v = {6'h00, serial2_nine_bit_o, serial2_receive_enable_o};
    chk("frame", 8'h03, v);
    chk("ninth", 8'h01, 8'(serial2_tx_ninth_bit_o));
    ev('{1'b0, 1'b1, 1'b1, 1'b1, 8'h5a}, fe0);
    rd(8'h8e, v);
    chk("control", 8'h9f, v);
    wr(8'h8f, 8'h33);
    chk("tx data", 8'h33, serial2_tx_data_o);
    rd(8'h8f, v);
    chk("rx data", 8'h5a, v);
    wr(8'h8e, 8'h98);
    rd(8'h8e, v);
    chk("done clear", 8'h98, v);
    wr(8'h8e, 8'h08);
    ev('{1'b0, 1'b0, 1'b1, 1'b1, 8'h11}, fe0);
    rd(8'h8e, v);
    chk("rx off", 8'h08, v);
    chk("ninth off", 8'h00, 8'(serial2_tx_ninth_bit_o));
    rd(8'h8f, v);
    chk("rx kept", 8'h5a, v);
    wr(8'h8e, 8'h10);
    ev('{1'b0, 1'b0, 1'b1, 1'b1, 8'h22}, fe0);
    rd(8'h8e, v);
    chk("8-bit rx", 8'h11, v);
    $display("serial test done");
    ev('0, 13'h140a);
    chk("flags set", 8'h37, interrupt_flags_o);
    e = 8'h37;
    foreach (clr[i]) begin
      wr(8'h95, clr[i]);
      e = e & clr[i];
      chk("flag clear", e, interrupt_flags_o);
    end
    ev('0, 13'h140a);
    ev('0, 13'h0b85);
    chk("flag service", 8'h00, interrupt_flags_o);
    wr(8'h96, 8'h00);
    ev('0, 13'h0108);
    chk("masked change", 8'h00, interrupt_flags_o);
    $display("flag test done");
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    chk("pp reset", 8'h00, port_zero_pushpull_enable_o);
    v = {4'h0, pin_two_one_mode_o, pin_two_zero_mode_o};
    chk("mode reset", 8'h05, v);
    $display("reset test done");
    print_verdict();
  end
  initial begin : watchdog
    #50000;
    mismatches++;
    print_verdict();
  end
endmodule : testbench
bind sfr_slice_serial2_port_option_flags
  sfr_slice_checker u_sfr_slice_checker (
  .clk_i, .reset_i, .bus_i, .rdata_o, .flag_ev_i, .serial2_nine_bit_o,
  .serial2_tx_ninth_bit_o, .serial2_tx_data_o, .serial2_tx_load_o,
  .port_zero_pushpull_enable_o, .interrupt_flags_o);
